// [inc/asx_pkg.sv]
`default_nettype none
package asx_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int BE_W = 2;
    localparam int LO_BYTE = 0;
    localparam int HI_BYTE = 1;
    // ----------------------------------------
    // clock and pin timing, ns
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_RC_NS = 70;
    localparam int T_AA_NS = 70;
    localparam int T_OE_NS = 35;
    localparam int T_HZ_NS = 25;
    localparam int T_WHZ_NS = 20;
    localparam int T_WC_NS = 70;
    localparam int T_CW_NS = 60;
    localparam int T_AW_NS = 60;
    localparam int T_AS_NS = 0;
    localparam int T_WP_NS = 50;
    localparam int T_WR_NS = 0;
    localparam int T_DW_NS = 30;
    localparam int T_DH_NS = 0;
    // ----------------------------------------
    // cycle counts: minimums rounded up, at least one
    // ----------------------------------------
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_ACC_CYC = ceil_cyc(T_AA_NS);
    localparam int RD_CYC = ceil_cyc(T_RC_NS);
    localparam int RD_HZ_CYC = ceil_cyc(T_HZ_NS);
    localparam int WR_SETUP_CYC = ceil_cyc(T_AS_NS);
    localparam int WR_PULSE_CYC = ceil_cyc((T_WP_NS > T_CW_NS) ? T_WP_NS : T_CW_NS);
    localparam int WR_PRE_CYC = ceil_cyc(T_WHZ_NS);
    localparam int WR_HOLD_CYC = ceil_cyc(T_WR_NS);
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h00000;
    localparam logic [BE_W-1:0] BE_OFF = 2'h3;
    typedef enum logic [2:0] {
        ASX_IDLE, ASX_RD_ACC, ASX_RD_REC, ASX_WR_PRE, ASX_WR_PULSE, ASX_WR_HOLD
    } asx_state_t;
endpackage
`default_nettype wire

// [hw/asx_lane_mux.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// per-byte-lane merge of captured read data
// ----------------------------------------
module asx_lane_mux import asx_pkg::*; (
    // lanes
    input wire logic [BE_W-1:0] lane_en,
    input wire logic [DATA_W-1:0] new_data,
    input wire logic [DATA_W-1:0] old_data,
    output logic [DATA_W-1:0] merged
);
    genvar g;
    generate
        for (g = 0; g < BE_W; g++) begin : g_lane
            assign merged[g*8 +: 8] = lane_en[g] ? new_data[g*8 +: 8] : old_data[g*8 +: 8];
        end
    endgenerate
endmodule // asx_lane_mux
`default_nettype wire

// [hw/asx_sram_host.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RULE_01] read: write high, output low, selected
// [RULE_02] standby when deselected or no byte lanes
// [RULE_03] write only during full select overlap
// [RULE_04] selects active before write-enable falls
// [RULE_05] write recovery at least zero ns
// [RULE_06] never drive data against device output
// [RULE_07] output enable to data within 35 ns
// [RULE_08] read sampled 70 ns after setup
// [RULE_09] device low-z delays tolerated
// [RULE_10] device releases bus within 25 ns
// [RULE_11] previous data held 10 ns
// [RULE_12] select 60 ns, cycle 70, pulse 50
// [RULE_13] address, byte enables 60 ns stable
// [RULE_14] data 30 ns before end, hold 0
// [RULE_15] device goes high-z 20 ns after write-enable
// [RULE_16] device may drive 5 ns after write
// [RULE_17] lower lane bits 7:0, upper 15:8
// [RULE_18] 512K words, 19-bit word address
module asx_sram_host import asx_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [BE_W-1:0] req_byte_en,
    // user answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // sram pins
    output logic [ADDR_W-1:0] sram_addr,
    output logic sram_select_active_low,
    output logic sram_select_active_high,
    output logic sram_output_enable_n,
    output logic sram_write_enable_n,
    output logic lower_byte_enable_n,
    output logic upper_byte_enable_n,
    input wire logic [DATA_W-1:0] sram_data_in,
    output logic [DATA_W-1:0] sram_data_out,
    output logic sram_data_oe
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    asx_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [BE_W-1:0] be_ff;
    logic wr_ff;
    logic sel_ff, oe_ff, we_ff, doe_ff;
    logic rsp_valid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] merged;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    assign req_ready = (state_ff == ASX_IDLE);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ASX_IDLE: begin
                if (req_valid && (req_byte_en != 2'h0)) begin
                    // selects asserted here with write-enable still high, so device outputs
                    // may turn on briefly; we wait them out before driving data
                    nxt_state = req_write ? ASX_WR_PRE : ASX_RD_ACC;
                    nxt_cnt = req_write ? cyc(WR_PRE_CYC + WR_SETUP_CYC - 1) : cyc(RD_ACC_CYC); // [RULE_08]
                end
            end
            ASX_RD_ACC: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ASX_RD_REC;
                    nxt_cnt = cyc(RD_HZ_CYC); // [RULE_10]
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ASX_RD_REC: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ASX_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ASX_WR_PRE: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ASX_WR_PULSE;
                    nxt_cnt = cyc(WR_PULSE_CYC); // [RULE_12]
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ASX_WR_PULSE: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ASX_WR_HOLD;
                    nxt_cnt = cyc(WR_HOLD_CYC); // [RULE_05]
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ASX_WR_HOLD: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ASX_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            default: begin
                nxt_state = ASX_IDLE;
                nxt_cnt = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ASX_IDLE;
            cnt_ff <= CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------
    // request capture; held whole cycle
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_ff <= ADDR_ZERO;
            wdata_ff <= DATA_ZERO;
            be_ff <= 2'h0;
            wr_ff <= 1'b0;
        end else if (req_ready && req_valid) begin
            addr_ff <= req_addr; // [RULE_13] [RULE_18]
            wdata_ff <= req_wdata; // [RULE_14]
            be_ff <= req_byte_en;
            wr_ff <= req_write;
        end
    end

    // ----------------------------------------
    // pin strobes, all from flops
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_ff <= 1'b0;
            oe_ff <= 1'b0;
            we_ff <= 1'b0;
            doe_ff <= 1'b0;
        end else begin
            // selects span whole access so write-enable is the last to fall and first to rise
            sel_ff <= (nxt_state != ASX_IDLE); // [RULE_02] [RULE_04] [RULE_12]
            oe_ff <= (nxt_state == ASX_RD_ACC); // [RULE_01] [RULE_07]
            we_ff <= (nxt_state == ASX_WR_PULSE); // [RULE_03]
            // drive data only while write-enable is low, device is then high-z
            doe_ff <= (nxt_state == ASX_WR_PULSE); // [RULE_06] [RULE_15] [RULE_16]
        end
    end

    assign sram_addr = addr_ff;
    assign sram_select_active_low = ~sel_ff;
    assign sram_select_active_high = sel_ff;
    assign sram_output_enable_n = ~oe_ff;
    assign sram_write_enable_n = ~we_ff;
    assign lower_byte_enable_n = ~(sel_ff & be_ff[LO_BYTE]); // [RULE_17]
    assign upper_byte_enable_n = ~(sel_ff & be_ff[HI_BYTE]); // [RULE_17]
    assign sram_data_out = wdata_ff;
    assign sram_data_oe = doe_ff;

    // ----------------------------------------
    // read capture, disabled lanes keep old value
    // ----------------------------------------
    asx_lane_mux u_lane_mux (
        .lane_en(be_ff),
        .new_data(sram_data_in),
        .old_data(rdata_ff),
        .merged(merged)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= DATA_ZERO;
            rsp_valid_ff <= 1'b0;
        end else begin
            // sample at end of access, before output enable drops; hold margin is ample
            rsp_valid_ff <= 1'b0;
            if (state_ff == ASX_RD_ACC && cnt_ff == CNT_ZERO) begin
                rdata_ff <= merged; // [RULE_08] [RULE_11]
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ASX_WR_HOLD && cnt_ff == CNT_ZERO) begin
                rsp_valid_ff <= 1'b1;
            end
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rdata_ff;
endmodule // asx_sram_host
`default_nettype wire

// [tb/asx_sram_host_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// pin protocol checks
// ----------------------------------------
module asx_sram_host_chk import asx_pkg::*; (
    // clock, reset, user side
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [BE_W-1:0] req_byte_en,
    input wire logic rsp_valid,
    // pins
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic sram_select_active_low,
    input wire logic sram_select_active_high,
    input wire logic sram_output_enable_n,
    input wire logic sram_write_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic upper_byte_enable_n,
    input wire logic sram_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire sel = !sram_select_active_low && sram_select_active_high;
    wire take = req_valid && req_ready && (req_byte_en != 2'h0);
    wire we = !sram_write_enable_n;
    a_no_clash: assert property (sram_data_oe |-> we && sram_output_enable_n)
        else $error("host drives data outside write pulse");
    a_write_overlap: assert property (we |-> sel && !(lower_byte_enable_n && upper_byte_enable_n))
        else $error("write without full select");
    a_pulse_len: assert property ($fell(sram_write_enable_n) |=> we ##1 we ##1 !we)
        else $error("write pulse length wrong");
    a_sel_setup: assert property ($fell(sram_write_enable_n) |-> $past(sel))
        else $error("select late for write");
    a_recovery: assert property ($rose(sram_write_enable_n) |-> sel && !sram_data_oe ##1 !sel)
        else $error("write recovery wrong");
    a_addr_stable: assert property (sel && $past(sel) |-> $stable(sram_addr)
        && $stable(lower_byte_enable_n) && $stable(upper_byte_enable_n)) else $error("address moved");
    a_oe_window: assert property ($fell(sram_output_enable_n) |-> sel ##1 sel[*2] ##1 sel && sram_output_enable_n)
        else $error("read window wrong");
    a_read_rsp: assert property (take && !req_write |=> !rsp_valid[*3] ##1 rsp_valid)
        else $error("read answer late");
    a_write_rsp: assert property (take && req_write |=> !rsp_valid[*5] ##1 rsp_valid)
        else $error("write answer late");
endmodule // asx_sram_host_chk
`default_nettype wire

// [tb/asx_sram_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// behavioural byte-laned static ram
// ----------------------------------------
module asx_sram_model import asx_pkg::*; #(
    parameter int ACC_NS = 70
) (
    // pins from host
    input wire logic [ADDR_W-1:0] addr,
    input wire logic sel_n,
    input wire logic sel,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic lb_n,
    input wire logic ub_n,
    input wire logic [DATA_W-1:0] din,
    input wire logic din_oe,
    // pins to host
    output logic [DATA_W-1:0] dout
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] last = 16'h0000;
    logic [DATA_W-1:0] word, wbuf;
    wire [DATA_W-1:0] bus_d;
    wire act = !sel_n && sel && !(lb_n && ub_n);
    wire rd = act && we_n && !oe_n;
    // delayed copy: pins change on the same edge as the write ends
    assign #1 bus_d = din_oe ? din : ~din;
    initial dout = 16'h0000;
    always @(rd or addr or lb_n or ub_n) begin
        word = mem.exists(int'(addr)) ? mem[int'(addr)] : ~last;
        if (rd) begin
            last = {ub_n ? ~last[15:8] : word[15:8], lb_n ? ~last[7:0] : word[7:0]};
            dout <= #(ACC_NS) last;
        end else begin
            dout <= #(T_WHZ_NS) ~last;
        end
    end
    always @(posedge we_n) begin
        if (act) begin
            wbuf = mem.exists(int'(addr)) ? mem[int'(addr)] : DATA_ZERO;
            if (!lb_n) wbuf[7:0] = bus_d[7:0];
            if (!ub_n) wbuf[15:8] = bus_d[15:8];
            mem[int'(addr)] = wbuf;
        end
    end
endmodule // asx_sram_model
`default_nettype wire

// [tb/asx_sram_host_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// random traffic over fixed boundary and bit-pattern addresses
// ----------------------------------------
module asx_sram_host_tb import asx_pkg::*;;
    logic clk, srst, req_valid, req_ready, req_write, rsp_valid, sram_data_oe;
    logic sram_select_active_low, sram_select_active_high, sram_output_enable_n;
    logic sram_write_enable_n, lower_byte_enable_n, upper_byte_enable_n;
    logic [ADDR_W-1:0] req_addr, sram_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, sram_data_in, sram_data_out, last_rd;
    logic [BE_W-1:0] req_byte_en;
    logic [31:0] seed = 32'h0000CC53;
    logic [DATA_W-1:0] ref_mem [int];
    logic [ADDR_W-1:0] addrs [8] = '{19'h00000, 19'h7FFFF, 19'h00001, 19'h40000, 19'h2AAAA, 19'h55555,
        19'h3FFFF, 19'h12345};
    int bad_count = 0;
    int n_compared = 0;
    asx_sram_host u_dut (.clk, .srst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .req_byte_en, .rsp_valid, .rsp_rdata, .sram_addr, .sram_select_active_low, .sram_select_active_high,
        .sram_output_enable_n, .sram_write_enable_n, .lower_byte_enable_n, .upper_byte_enable_n,
        .sram_data_in, .sram_data_out, .sram_data_oe);
    asx_sram_model u_mem (.addr(sram_addr), .sel_n(sram_select_active_low), .sel(sram_select_active_high),
        .oe_n(sram_output_enable_n), .we_n(sram_write_enable_n), .lb_n(lower_byte_enable_n),
        .ub_n(upper_byte_enable_n), .din(sram_data_out), .din_oe(sram_data_oe), .dout(sram_data_in));
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [BE_W-1:0] be);
        merge = o;
        if (be[LO_BYTE]) merge[7:0] = n[7:0];
        if (be[HI_BYTE]) merge[15:8] = n[15:8];
    endfunction
    task automatic check1(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check16(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one request, held until taken; a zero lane mask must get no answer
    task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [BE_W-1:0] be);
        int n;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_byte_en = be;
        for (n = 0; req_ready !== 1'b1 && n < 20; n++) @(posedge clk) #1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (n = 0; rsp_valid !== 1'b1 && n < 8; n++) @(posedge clk) #1;
        check1("response", be != 2'h0, rsp_valid);
        if (wr) ref_mem[a] = merge(ref_mem[a], d, be);
        else if (be != 2'h0) begin
            last_rd = merge(last_rd, ref_mem[a], be);
            check16("read data", last_rd, rsp_rdata);
        end
    endtask
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = ADDR_ZERO;
        req_wdata = DATA_ZERO;
        req_byte_en = 2'h0;
        last_rd = DATA_ZERO;
        repeat (8) @(posedge clk);
        check1("select idle", 1'b1, sram_select_active_low);
        #1 srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            do_op(1'b1, addrs[i], seed[15:0], 2'h3);
        end
        do_op(1'b0, addrs[1], DATA_ZERO, 2'h3);
        repeat (150) begin
            seed = xs(seed);
            do_op(seed[5], addrs[seed[2:0]], seed[31:16], seed[4:3]);
        end
        test_done();
    end
    initial begin
        #(CLK_PERIOD_NS * 10000);
        bad_count++;
        test_done();
    end
endmodule // asx_sram_host_tb
bind asx_sram_host asx_sram_host_chk u_chk (.clk, .srst, .req_valid, .req_ready, .req_write, .req_byte_en,
    .rsp_valid, .sram_addr, .sram_select_active_low, .sram_select_active_high, .sram_output_enable_n,
    .sram_write_enable_n, .lower_byte_enable_n, .upper_byte_enable_n, .sram_data_oe);
`default_nettype wire
